// ===== src/bridge_pm_regs.svh
`ifndef BRIDGE_PM_REGS_SVH
`define BRIDGE_PM_REGS_SVH

// Byte addresses of the dwords holding each register.
`define SUBSYS_DW_ADDR 8'h2c
`define SERR_CAUSE_DW_ADDR 8'h68
`define ROR_CTRL_DW_ADDR 8'h9c
`define PM_CAP_DW_ADDR 8'hdc
`define PM_CSR_DW_ADDR 8'he0
`define HOTSWAP_DW_ADDR 8'he4

// Register byte offsets.
`define SUBSYS_VENDOR_OFFSET 8'h2c
`define SUBSYS_ID_OFFSET 8'h2e
`define SERR_CAUSE_OFFSET 8'h6a
`define ROR_CTRL_OFFSET 8'h9c
`define PM_CAP_ID_OFFSET 8'hdc
`define PM_NEXT_OFFSET 8'hdd
`define PM_CAPS_OFFSET 8'hde
`define PM_CSR_OFFSET 8'he0
`define PM_BRIDGE_OFFSET 8'he2
`define PM_DATA_OFFSET 8'he3
`define HS_CAP_ID_OFFSET 8'he4
`define HS_NEXT_OFFSET 8'he5
`define HS_CTRL_OFFSET 8'he6

// Fixed values and reset values.
`define PM_CAP_ID_VALUE 8'h01
`define PM_NEXT_VALUE 8'he4
`define HS_CAP_ID_VALUE 8'h06
`define HS_NEXT_VALUE 8'he8
`define PM_VERSION_VALUE 3'h1
`define SERR_CAUSE_RESET 8'h00
`define ROR_CTRL_RESET 8'h00
`define ROR_ENABLE_RESET 1'b0
`define PM_STATE_RESET 2'h0
`define PM_PME_SUPPORT_RESET 5'h00
`define PM_DATA_RESET 8'h00

// Field positions.
`define ROR_ENABLE_BIT 7
`define PM_CAPS_D1_BIT 9
`define PM_CAPS_D2_BIT 10
`define PM_CAPS_PME_LSB 11
`define BRIDGE_CLK_STOP_BIT 6
`define BRIDGE_BUS_PWR_BIT 7

// Power-state encodings.
`define PM_STATE_D3HOT 2'h3

`endif

// ===== src/bridge_pm_pkg.sv
package bridge_pm_pkg;

    typedef enum logic [1:0] {
        PS_D0 = 2'h0,
        PS_D1 = 2'h1,
        PS_D2 = 2'h2,
        PS_D3HOT = 2'h3
    } power_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] dw_addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } cfg_req_t;

    typedef struct packed {
        logic [15:0] subsys_vendor;
        logic [15:0] subsys_id;
        logic [4:0] pme_support;
        logic [7:0] pm_data;
    } eeprom_load_t;

endpackage : bridge_pm_pkg

// ===== src/bridge_error_pm_capability_regs.sv
`timescale 1ns/100ps
`include "bridge_pm_regs.svh"

module bridge_error_pm_capability_regs #(
    parameter logic [15:0] SUBSYS_VENDOR_RESET = 16'h0000,
    parameter logic [15:0] SUBSYS_ID_RESET = 16'h0000
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    // Configuration access from the primary bus
    input wire bridge_pm_pkg::cfg_req_t cfg_req_in,
    output logic [31:0] cfg_rdata_out,
    output logic cfg_rvalid_out,
    // Serial EEPROM load
    input wire logic eeprom_load_in,
    input wire bridge_pm_pkg::eeprom_load_t eeprom_data_in,
    // System error causes, one-cycle pulses from the forwarding logic
    input wire logic [7:0] serr_cause_in,
    // Bus power/clock control strap pin
    input wire logic bus_power_clock_ctrl_pin_in,
    // Power-management outputs and the read-only override enable
    output bridge_pm_pkg::power_state_t power_state_out,
    output logic secondary_clock_stop_out,
    output bridge_pm_pkg::power_state_t secondary_bus_state_out,
    output logic readonly_override_enable_out
);

    logic rst_meta_reg;
    logic rst_sync_reg;
    logic pin_meta_reg;
    logic pin_sync_reg;
    logic [7:0] serr_cause_reg;
    logic [7:0] serr_cause_next;
    logic ror_enable_reg;
    logic [15:0] subsys_vendor_reg;
    logic [15:0] subsys_id_reg;
    logic [4:0] pme_support_reg;
    logic [7:0] pm_data_reg;
    bridge_pm_pkg::power_state_t power_state_reg;
    logic [15:0] pm_caps;
    logic [15:0] pm_csr;
    logic [7:0] pm_bridge;
    logic [31:0] rdata_next;
    logic wr_subsys;
    logic wr_serr;
    logic wr_ror;
    logic wr_pmcap;
    logic wr_pm_control_status;

    // Reset is asserted at once but released only after two clean edges.
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // The strap pin is asynchronous to the bus clock.
    always_ff @(posedge core_clk_in or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
        end else begin
            pin_meta_reg <= bus_power_clock_ctrl_pin_in;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    assign wr_subsys = cfg_req_in.wr && (cfg_req_in.dw_addr == `SUBSYS_DW_ADDR);
    assign wr_serr = cfg_req_in.wr && (cfg_req_in.dw_addr == `SERR_CAUSE_DW_ADDR);
    assign wr_ror = cfg_req_in.wr && (cfg_req_in.dw_addr == `ROR_CTRL_DW_ADDR);
    assign wr_pmcap = cfg_req_in.wr && (cfg_req_in.dw_addr == `PM_CAP_DW_ADDR);
    assign wr_pm_control_status = cfg_req_in.wr && (cfg_req_in.dw_addr == `PM_CSR_DW_ADDR);

    // Cause bits sit in byte lane 2 of their dword.
    always_comb begin
        serr_cause_next = serr_cause_reg;
        if (wr_serr && cfg_req_in.be[2]) begin
            serr_cause_next = serr_cause_next & ~cfg_req_in.wdata[23:16];
        end
        serr_cause_next = serr_cause_next | serr_cause_in;
    end

    always_ff @(posedge core_clk_in or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            serr_cause_reg <= `SERR_CAUSE_RESET;
        end else begin
            serr_cause_reg <= serr_cause_next;
        end
    end

    // Only bit 7 of the control byte is implemented.
    always_ff @(posedge core_clk_in or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            ror_enable_reg <= `ROR_ENABLE_RESET;
        end else if (wr_ror && cfg_req_in.be[0]) begin
            ror_enable_reg <= cfg_req_in.wdata[`ROR_ENABLE_BIT];
        end
    end

    // An EEPROM load takes priority over a concurrent override write.
    always_ff @(posedge core_clk_in or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            subsys_vendor_reg <= SUBSYS_VENDOR_RESET;
            subsys_id_reg <= SUBSYS_ID_RESET;
        end else if (eeprom_load_in) begin
            subsys_vendor_reg <= eeprom_data_in.subsys_vendor;
            subsys_id_reg <= eeprom_data_in.subsys_id;
        end else if (wr_subsys && ror_enable_reg) begin
            if (cfg_req_in.be[0]) begin
                subsys_vendor_reg[7:0] <= cfg_req_in.wdata[7:0];
            end
            if (cfg_req_in.be[1]) begin
                subsys_vendor_reg[15:8] <= cfg_req_in.wdata[15:8];
            end
            if (cfg_req_in.be[2]) begin
                subsys_id_reg[7:0] <= cfg_req_in.wdata[23:16];
            end
            if (cfg_req_in.be[3]) begin
                subsys_id_reg[15:8] <= cfg_req_in.wdata[31:24];
            end
        end
    end

    // Only the event-support field of the capabilities word is storage;
    // the other capability bits are fixed by construction.
    always_ff @(posedge core_clk_in or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            pme_support_reg <= `PM_PME_SUPPORT_RESET;
        end else if (eeprom_load_in) begin
            pme_support_reg <= eeprom_data_in.pme_support;
        end else if (wr_pmcap && ror_enable_reg && cfg_req_in.be[3]) begin
            pme_support_reg <= cfg_req_in.wdata[31:27];
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            pm_data_reg <= `PM_DATA_RESET;
        end else if (eeprom_load_in) begin
            pm_data_reg <= eeprom_data_in.pm_data;
        end else if (wr_pm_control_status && ror_enable_reg && cfg_req_in.be[3]) begin
            pm_data_reg <= cfg_req_in.wdata[31:24];
        end
    end

    // The power state is writable at any time; no other bit of the
    // control/status word holds state, so the override adds nothing here.
    always_ff @(posedge core_clk_in or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            power_state_reg <= bridge_pm_pkg::PS_D0;
        end else if (wr_pm_control_status && cfg_req_in.be[0]) begin
            power_state_reg <= bridge_pm_pkg::power_state_t'(cfg_req_in.wdata[1:0]);
        end
    end

    always_comb begin
        pm_caps = 16'h0000;
        pm_caps[2:0] = `PM_VERSION_VALUE;
        pm_caps[`PM_CAPS_D1_BIT] = 1'b1;
        pm_caps[`PM_CAPS_D2_BIT] = 1'b1;
        pm_caps[15:`PM_CAPS_PME_LSB] = pme_support_reg;
    end

    assign pm_csr = {14'h0000, power_state_reg};

    always_comb begin
        pm_bridge = 8'h00;
        pm_bridge[`BRIDGE_CLK_STOP_BIT] = pin_sync_reg;
        pm_bridge[`BRIDGE_BUS_PWR_BIT] = pin_sync_reg;
    end

    // Unmapped dwords read zero, so a stray read is harmless.
    always_comb begin
        unique case (cfg_req_in.dw_addr)
            `SUBSYS_DW_ADDR: rdata_next = {subsys_id_reg, subsys_vendor_reg};
            `SERR_CAUSE_DW_ADDR: rdata_next = {8'h00, serr_cause_reg, 16'h0000};
            `ROR_CTRL_DW_ADDR: rdata_next = {24'h000000, ror_enable_reg, 7'h00};
            `PM_CAP_DW_ADDR: rdata_next = {pm_caps, `PM_NEXT_VALUE, `PM_CAP_ID_VALUE};
            `PM_CSR_DW_ADDR: rdata_next = {pm_data_reg, pm_bridge, pm_csr};
            `HOTSWAP_DW_ADDR: rdata_next = {16'h0000, `HS_NEXT_VALUE, `HS_CAP_ID_VALUE};
            default: rdata_next = 32'h00000000;
        endcase
    end

    // Read data is returned one cycle after the request.
    always_ff @(posedge core_clk_in or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            cfg_rdata_out <= 32'h00000000;
            cfg_rvalid_out <= 1'b0;
        end else begin
            cfg_rvalid_out <= cfg_req_in.rd;
            cfg_rdata_out <= cfg_req_in.rd ? rdata_next : 32'h00000000;
        end
    end

    // Secondary clock and power follow the registered state while the pin
    // copy is high; that copy lags the pin by two clocks, which the bus never notices.
    always_ff @(posedge core_clk_in or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            power_state_out <= bridge_pm_pkg::PS_D0;
            secondary_clock_stop_out <= 1'b0;
            secondary_bus_state_out <= bridge_pm_pkg::PS_D0;
            readonly_override_enable_out <= 1'b0;
        end else begin
            power_state_out <= power_state_reg;
            secondary_clock_stop_out <= pin_sync_reg &&
                (power_state_reg == bridge_pm_pkg::PS_D3HOT);
            if (pin_sync_reg && power_state_reg != bridge_pm_pkg::PS_D3HOT) begin
                secondary_bus_state_out <= power_state_reg;
            end else if (pin_sync_reg) begin
                secondary_bus_state_out <= bridge_pm_pkg::PS_D3HOT;
            end else begin
                secondary_bus_state_out <= bridge_pm_pkg::PS_D0;
            end
            readonly_override_enable_out <= ror_enable_reg;
        end
    end

endmodule : bridge_error_pm_capability_regs

// ===== verif/bridge_pm_regs_properties.sv
`timescale 1ns/100ps
module bridge_pm_regs_checker (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    // Configuration port
    input wire bridge_pm_pkg::cfg_req_t cfg_req_in,
    input wire logic [31:0] cfg_rdata_out,
    input wire logic cfg_rvalid_out,
    // Causes, pin and power outputs
    input wire logic [7:0] serr_cause_in,
    input wire logic bus_power_clock_ctrl_pin_in,
    input wire bridge_pm_pkg::power_state_t power_state_out,
    input wire logic secondary_clock_stop_out,
    input wire bridge_pm_pkg::power_state_t secondary_bus_state_out
);
    logic r;
    logic w;
    logic [7:0] a;
    logic [7:0] wb;
    logic [1:0] ws;
    logic p;
    logic [3:0] up_cnt;
    logic [3:0] hist;
    logic calm;
    assign r = cfg_req_in.rd;
    assign w = cfg_req_in.wr;
    assign a = cfg_req_in.dw_addr;
    assign wb = cfg_req_in.wdata[23:16];
    assign ws = cfg_req_in.wdata[1:0];
    assign p = bus_power_clock_ctrl_pin_in;
    // The synchronised pin reads low for a while after reset, so pin checks wait until calm.
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            up_cnt <= 4'h0;
            hist <= 4'h0;
        end else begin
            up_cnt <= (up_cnt == 4'h8) ? up_cnt : up_cnt + 4'h1;
            hist <= {hist[2:0], p};
        end
    end
    assign calm = (up_cnt == 4'h8) && (hist == {4{p}});
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_b_in);
    chk_pm_id_chain: assert property (
        r && a == 8'hdc |=> cfg_rvalid_out && cfg_rdata_out[15:0] == 16'he401)
        else $error("pm id wrong");
    chk_caps_fixed: assert property (
        r && a == 8'hdc |=> cfg_rdata_out[26:16] == 11'h601) else $error("caps wrong");
    chk_hotswap_fixed: assert property (
        r && a == 8'he4 |=> cfg_rdata_out == 32'h0000e806) else $error("hot swap wrong");
    chk_cause_set: assert property (
        (serr_cause_in != 8'h0) ##2 (r && a == 8'h68) |=>
        (cfg_rdata_out[23:16] & $past(serr_cause_in, 3)) == $past(serr_cause_in, 3))
        else $error("cause not set");
    chk_cause_w1c: assert property (
        (w && a == 8'h68 && cfg_req_in.be[2] && serr_cause_in == 8'h0) ##1
        (serr_cause_in == 8'h0) ##1 (r && a == 8'h68) |=>
        (cfg_rdata_out[23:16] & $past(wb, 3)) == 8'h0) else $error("cause not cleared");
    chk_state_follow: assert property (
        w && a == 8'he0 && cfg_req_in.be[0] |=> ##1 power_state_out == $past(ws, 2))
        else $error("state wrong");
    chk_clock_stop: assert property (
        calm |-> secondary_clock_stop_out == (p && power_state_out == bridge_pm_pkg::PS_D3HOT))
        else $error("clock stop wrong");
    chk_bus_state: assert property (
        calm |-> secondary_bus_state_out == (p ? power_state_out : bridge_pm_pkg::PS_D0))
        else $error("bus state wrong");
    chk_read_valid: assert property (
        r |=> cfg_rvalid_out) else $error("read valid missing");
    chk_idle_quiet: assert property (
        !r |=> !cfg_rvalid_out && cfg_rdata_out == 32'h0) else $error("idle read data");
    cov_cause_read: cover property ((serr_cause_in != 8'h0) ##2 (r && a == 8'h68));
    cov_clock_stop: cover property (secondary_clock_stop_out);
    cov_override: cover property (w && a == 8'h9c && cfg_req_in.wdata[7]);
endmodule : bridge_pm_regs_checker

bind bridge_error_pm_capability_regs bridge_pm_regs_checker u_bridge_pm_regs_checker (
    .core_clk_in, .rst_b_in, .cfg_req_in, .cfg_rdata_out, .cfg_rvalid_out, .serr_cause_in,
    .bus_power_clock_ctrl_pin_in, .power_state_out, .secondary_clock_stop_out,
    .secondary_bus_state_out
);

// ===== verif/cfg_master_model.sv
`timescale 1ns/100ps
module cfg_master_model (
    // Clock
    input wire logic core_clk_in,
    // Request and answer
    output bridge_pm_pkg::cfg_req_t req_out,
    input wire logic [31:0] rdata_in
);
    initial req_out = '0;
    // Released address, enable and data lines carry the inverse of the last value, never a stale copy.
    task automatic idle();
        req_out <= '{1'b0, 1'b0, ~req_out.dw_addr, ~req_out.be, ~req_out.wdata};
    endtask : idle
    task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
        @(posedge core_clk_in) req_out <= '{1'b1, 1'b0, a, b, d};
        @(posedge core_clk_in) idle();
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk_in) req_out <= '{1'b0, 1'b1, a, 4'h0, 32'h0};
        @(posedge core_clk_in) idle();
        // Read data stands only until the next edge, so take it now.
        #1;
        d = rdata_in;
    endtask : rd
endmodule : cfg_master_model

// ===== verif/testbench.sv
`timescale 1ns/100ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin miscompares++; \
    $display("BAD %s exp %h got %h", n, e, s); end end
module testbench;
    logic core_clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    bridge_pm_pkg::cfg_req_t cfg_req_in;
    logic [31:0] cfg_rdata_out;
    logic cfg_rvalid_out;
    logic eeprom_load_in = 1'b0;
    bridge_pm_pkg::eeprom_load_t eeprom_data_in = '0;
    logic [7:0] serr_cause_in = 8'h00;
    logic bus_power_clock_ctrl_pin_in = 1'b0;
    bridge_pm_pkg::power_state_t power_state_out;
    bridge_pm_pkg::power_state_t secondary_bus_state_out;
    logic secondary_clock_stop_out;
    logic readonly_override_enable_out;
    int miscompares = 0;
    int check_count = 0;
    int cycles = 0;
    logic [31:0] cb;
    logic [1:0] st;
    logic pw;
    logic [7:0] row_a[7] = '{8'h68, 8'hdc, 8'he0, 8'he4, 8'h9c, 8'h2c, 8'h40};
    logic [31:0] row_d[7] = '{0, 32'h0601e401, 0, 32'h0000e806, 0, 0, 0};
    logic [7:0] ow_a[3] = '{8'h2c, 8'hdc, 8'he0};
    logic [3:0] ow_b[3] = '{4'hf, 4'h8, 4'h8};
    logic [31:0] ow_d[3] = '{32'h22221111, 32'hf8000000, 32'hab000000};
    logic [31:0] ow_m[3] = '{32'hffffffff, 32'hf8000000, 32'hff000000};
    bridge_error_pm_capability_regs u_bridge_error_pm_capability_regs (
        .core_clk_in, .rst_b_in, .cfg_req_in, .cfg_rdata_out, .cfg_rvalid_out,
        .eeprom_load_in, .eeprom_data_in, .serr_cause_in, .bus_power_clock_ctrl_pin_in,
        .power_state_out, .secondary_clock_stop_out, .secondary_bus_state_out,
        .readonly_override_enable_out
    );
    cfg_master_model u_cfg_master_model (
        .core_clk_in, .req_out(cfg_req_in), .rdata_in(cfg_rdata_out)
    );
    always #25 core_clk_in = ~core_clk_in;
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim
    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        logic [31:0] d;
        u_cfg_master_model.rd(a, d);
        `CHK($sformatf("reg %h", a), e & m, d & m)
    endtask : rdc
    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            end_sim();
        end
    end
    initial begin
        repeat (3) @(posedge core_clk_in);
        rst_b_in <= 1'b1;
        repeat (3) @(posedge core_clk_in);
        for (int i = 0; i < 7; i++) begin
            rdc(row_a[i], row_d[i], '1);
        end
        $display("test reset values done");
        for (int n = 0; n < 8; n++) begin
            cb = {8'h00, 8'h01 << n, 16'h0000};
            @(posedge core_clk_in) serr_cause_in <= 8'h01 << n;
            @(posedge core_clk_in) serr_cause_in <= 8'h00;
            rdc(8'h68, cb, 32'h00ff0000);
            u_cfg_master_model.wr(8'h68, 4'h4, 32'h0);
            rdc(8'h68, cb, 32'h00ff0000);
            u_cfg_master_model.wr(8'h68, 4'h4, cb);
            rdc(8'h68, 32'h0, 32'h00ff0000);
        end
        $display("test cause bits done");
        for (int p = 0; p < 3; p++) begin
            u_cfg_master_model.wr(8'h9c, 4'h1, (p == 1) ? 32'h80 : 32'h0);
            for (int i = 0; i < 3; i++) begin
                u_cfg_master_model.wr(ow_a[i], ow_b[i], (p == 2) ? ~ow_d[i] : ow_d[i]);
                rdc(ow_a[i], (p == 0) ? 32'h0 : ow_d[i], ow_m[i]);
            end
            `CHK("override", p == 1, readonly_override_enable_out)
        end
        $display("test override done");
        for (int s = 0; s < 5; s++) begin
            st = (s == 4) ? 2'h3 : 2'(s);
            pw = (s < 4);
            @(posedge core_clk_in) bus_power_clock_ctrl_pin_in <= pw;
            u_cfg_master_model.wr(8'he0, 4'h1, {30'h0, st});
            repeat (4) @(posedge core_clk_in);
            #1;
            `CHK("state", st, power_state_out)
            `CHK("clock stop", pw && st == 2'h3, secondary_clock_stop_out)
            `CHK("bus state", pw ? st : 2'h0, secondary_bus_state_out)
            rdc(8'he0, {8'h00, {2{pw}}, 20'h0, st}, 32'h00ffffff);
        end
        $display("test power states done");
        u_cfg_master_model.wr(8'he4, 4'hf, 32'hffffffff);
        rdc(8'he4, 32'h0000e806, '1);
        @(posedge core_clk_in) begin
            eeprom_data_in <= '{16'h1234, 16'h5678, 5'h15, 8'h9a};
            eeprom_load_in <= 1'b1;
        end
        @(posedge core_clk_in) eeprom_load_in <= 1'b0;
        rdc(8'h2c, 32'h56781234, '1);
        rdc(8'hdc, 32'hae01e401, '1);
        rdc(8'he0, 32'h9a000000, 32'hff000000);
        $display("test loads done");
        u_cfg_master_model.wr(8'h9c, 4'h1, 32'h80);
        @(posedge core_clk_in) serr_cause_in <= 8'hff;
        @(posedge core_clk_in) serr_cause_in <= 8'h00;
        @(posedge core_clk_in) rst_b_in <= 1'b0;
        repeat (3) @(posedge core_clk_in);
        rst_b_in <= 1'b1;
        repeat (3) @(posedge core_clk_in);
        rdc(8'h68, 32'h0, '1);
        rdc(8'h9c, 32'h0, '1);
        rdc(8'he0, 32'h0, 32'h0000ffff);
        $display("test second reset done");
        end_sim();
    end
endmodule : testbench
